// ---- hw/bssp_defs.svh ----
/*
  Constants of the burst synchronous SRAM port: geometry, lane positions
  and burst counter width and reset values. Assumes inclusion by bare name.
*/
`ifndef BSSP_DEFS_SVH
`define BSSP_DEFS_SVH
`define BSSP_ADDR_W 16
`define BSSP_DATA_W 16
`define BSSP_PAR_W 2
`define BSSP_WORD_W 18
`define BSSP_DEPTH 65536
`define BSSP_LO_DATA_LSB 0
`define BSSP_HI_DATA_LSB 8
`define BSSP_LANE_W 8
`define BSSP_BURST_W 2
`define BSSP_CNT_RST 2'h0
`define BSSP_ADDR_RST 16'h0000
`endif

// ---- hw/bssp_pkg.sv ----
/*
  Types of the burst synchronous SRAM port.
  Assumes bssp_defs.svh is on the include path.
*/
`include "bssp_defs.svh"
package bssp_pkg;
  typedef enum logic [0:0] {
    BSSP_ORDER_INTERLEAVED = 1'b0,
    BSSP_ORDER_LINEAR = 1'b1
  } bssp_order_t;
  typedef enum logic [1:0] {
    BSSP_ST_IDLE = 2'b00,
    BSSP_ST_READ = 2'b01,
    BSSP_ST_WRPEND = 2'b10
  } bssp_state_t;
endpackage : bssp_pkg

// ---- hw/bssp_port.sv ----
/*
  Synchronous burst cache RAM, 64K x 18, common data and parity I/O.
  Assumes strobes and data come from logic on mclk; the output enable is
  an asynchronous pin applied combinationally to the output enables.
*/
// What this block does
// - 65536 words of 16 data plus 2 parity bits, 16 address inputs.
// - Select and processor strobe low at edge start access, load address and counter.
// - Byte writes ignored in processor strobe cycle; such writes take two cycles.
// - Byte write low at edge after processor strobe stores data at counter address.
// - Low write gates bits 7..0 and parity 0; high write bits 15..8, parity 1.
// - Lanes sampled for writing are high impedance regardless of output enable.
// - Select, controller strobe and byte write low write in one cycle.
// - Controller write loads address register and counter, writes at counter address.
// - Strobe with both writes high starts read, driven while output enable low.
// - Output enable acts asynchronously; select is sampled only on clock edges.
// - Two-bit wrap counter loaded from address bits 1..0 gives burst low bits.
// - Interleaved order steps by XOR of start with 00, 01, 10, 11.
// - Linear order steps by adding one modulo four.
// - Counter steps only under the advance input.
// - Advance low at edge steps the counter once.
// - Advance ignored when a strobe is low with select low.
// - Processor strobe ignored entirely while select is high.
// - Select high with controller strobe low deselects the device.
`timescale 1ns/1ps
`include "bssp_defs.svh"
module bssp_port
  import bssp_pkg::*;
#(
  parameter bssp_order_t ORDER = BSSP_ORDER_INTERLEAVED
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Access control
  input wire logic bank_select_n,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic write_upper_n,
  input wire logic write_lower_n,
  input wire logic out_drive_en_n,
  input wire logic [`BSSP_ADDR_W-1:0] addr_in,
  // Data and parity lines, split into in, out and active-low enable
  input wire logic [`BSSP_DATA_W-1:0] data_lines_in,
  output logic [`BSSP_DATA_W-1:0] data_lines_out,
  output logic [`BSSP_DATA_W-1:0] data_lines_oe_n,
  input wire logic [`BSSP_PAR_W-1:0] parity_lines_in,
  output logic [`BSSP_PAR_W-1:0] parity_lines_out,
  output logic [`BSSP_PAR_W-1:0] parity_lines_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage; no reset on the array, like a real RAM core
  logic [`BSSP_WORD_W-1:0] mem [`BSSP_DEPTH];

  function automatic logic [`BSSP_BURST_W-1:0] next_low(
    input logic [`BSSP_BURST_W-1:0] cur,
    input logic [`BSSP_BURST_W-1:0] start
  );
    logic [`BSSP_BURST_W-1:0] step;
    step = cur ^ start;
    step = step + 2'h1;
    if (ORDER == BSSP_ORDER_LINEAR) begin
      next_low = cur + 2'h1;
    end else begin
      next_low = start ^ step;
    end
  endfunction : next_low

  ////////////////////////////////////////////////////////////////////////////
  // Sampled controls
  logic sel;
  logic p_start;
  logic c_start;
  logic start;
  logic wr_any;
  assign sel = ~bank_select_n;
  assign p_start = sel & ~proc_addr_strobe_n;
  assign c_start = sel & ~ctrl_addr_strobe_n;
  assign start = p_start | c_start;
  assign wr_any = ~write_upper_n | ~write_lower_n;

  bssp_state_t state_reg, state_next;
  logic [`BSSP_ADDR_W-1:0] addr_reg, addr_next;
  logic [`BSSP_BURST_W-1:0] cnt_reg, cnt_next;
  logic [`BSSP_BURST_W-1:0] start_reg, start_next;
  logic do_write;
  logic [1:0] lane_we;

  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    cnt_next = cnt_reg;
    start_next = start_reg;
    do_write = 1'b0;
    lane_we = 2'b00;
    if (start) begin
      addr_next = addr_in;
      cnt_next = addr_in[`BSSP_BURST_W-1:0];
      start_next = addr_in[`BSSP_BURST_W-1:0];
      if (p_start) begin
        // Processor strobe wins; byte writes are looked at next edge
        state_next = BSSP_ST_WRPEND;
      end else if (wr_any) begin
        do_write = 1'b1;
        lane_we = {~write_upper_n, ~write_lower_n};
        state_next = BSSP_ST_IDLE;
      end else begin
        state_next = BSSP_ST_READ;
      end
    end else begin
      if (!burst_advance_n) begin
        cnt_next = next_low(cnt_reg, start_reg);
      end
      if (state_reg != BSSP_ST_IDLE && wr_any) begin
        do_write = 1'b1;
        lane_we = {~write_upper_n, ~write_lower_n};
        state_next = BSSP_ST_WRPEND;
      end else if (state_reg == BSSP_ST_WRPEND) begin
        state_next = BSSP_ST_READ;
      end
      if (bank_select_n && !ctrl_addr_strobe_n) begin
        state_next = BSSP_ST_IDLE;
        do_write = 1'b0;
        lane_we = 2'b00;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= BSSP_ST_IDLE;
      addr_reg <= `BSSP_ADDR_RST;
      cnt_reg <= `BSSP_CNT_RST;
      start_reg <= `BSSP_CNT_RST;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      cnt_reg <= cnt_next;
      start_reg <= start_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array write and registered read; write address uses the counter bits
  logic [`BSSP_ADDR_W-1:0] waddr;
  logic [`BSSP_ADDR_W-1:0] raddr;
  assign waddr = {addr_next[`BSSP_ADDR_W-1:`BSSP_BURST_W], cnt_next};
  assign raddr = waddr;

  always_ff @(posedge mclk) begin
    if (do_write && lane_we[0]) begin
      mem[waddr][`BSSP_LANE_W-1:0] <= data_lines_in[`BSSP_LANE_W-1:0];
      mem[waddr][`BSSP_DATA_W] <= parity_lines_in[0];
    end
    if (do_write && lane_we[1]) begin
      mem[waddr][`BSSP_HI_DATA_LSB +: `BSSP_LANE_W] <=
        data_lines_in[`BSSP_HI_DATA_LSB +: `BSSP_LANE_W];
      mem[waddr][`BSSP_DATA_W+1] <= parity_lines_in[1];
    end
  end

  logic [`BSSP_WORD_W-1:0] rdata_reg;
  logic [1:0] lane_off_reg, lane_off_next;
  logic drive_reg, drive_next;
  always_comb begin
    lane_off_next = {~write_upper_n, ~write_lower_n};
    drive_next = (state_next != BSSP_ST_IDLE);
  end

  always_ff @(posedge mclk) begin
    rdata_reg <= mem[raddr];
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lane_off_reg <= 2'b00;
      drive_reg <= 1'b0;
    end else begin
      lane_off_reg <= lane_off_next;
      drive_reg <= drive_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output enable is combinational on purpose: the pin is asynchronous
  logic [1:0] lane_en;
  assign lane_en = {2{drive_reg & ~out_drive_en_n}} & ~lane_off_reg;
  always_comb begin
    data_lines_out = rdata_reg[`BSSP_DATA_W-1:0];
    parity_lines_out = rdata_reg[`BSSP_WORD_W-1:`BSSP_DATA_W];
    data_lines_oe_n = {{`BSSP_LANE_W{~lane_en[1]}}, {`BSSP_LANE_W{~lane_en[0]}}};
    parity_lines_oe_n = ~lane_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_pstart;
    !bank_select_n && !proc_addr_strobe_n;
  endsequence
  // Second edge of a processor write: no new access, no deselect, low lane written
  sequence s_wr_low_held;
    (bank_select_n ? ctrl_addr_strobe_n : proc_addr_strobe_n && ctrl_addr_strobe_n) &&
      !write_lower_n;
  endsequence
  sequence s_cwrite;
    !bank_select_n && !ctrl_addr_strobe_n && proc_addr_strobe_n &&
      (!write_upper_n || !write_lower_n);
  endsequence

  chk_addr_load: assert property (@(posedge mclk) disable iff (!arst_n)
    s_pstart |=> addr_reg == $past(addr_in))
    else $error("address not loaded on processor strobe");
  chk_pstrobe_nowrite: assert property (@(posedge mclk) disable iff (!arst_n)
    s_pstart |-> !do_write)
    else $error("write taken in processor strobe cycle");
  chk_second_write: assert property (@(posedge mclk) disable iff (!arst_n)
    s_pstart ##1 s_wr_low_held |-> do_write && lane_we[0])
    else $error("second-cycle write missing");
  chk_ctrl_write: assert property (@(posedge mclk) disable iff (!arst_n)
    s_cwrite |-> do_write && waddr == addr_in)
    else $error("controller write missing");
  chk_lane_off: assert property (@(posedge mclk) disable iff (!arst_n)
    !write_lower_n |=> parity_lines_oe_n[0])
    else $error("low lane driven in write cycle");
  chk_lane_off_hi: assert property (@(posedge mclk) disable iff (!arst_n)
    !write_upper_n |=> parity_lines_oe_n[1] && &data_lines_oe_n[15:8])
    else $error("high lane driven in write cycle");
  chk_desel_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
    bank_select_n && !ctrl_addr_strobe_n |-> !do_write)
    else $error("write taken while deselected");
  chk_adv_ignored: assert property (@(posedge mclk) disable iff (!arst_n)
    !bank_select_n && !ctrl_addr_strobe_n |=> cnt_reg == $past(addr_in[1:0]))
    else $error("advance overrode address load");
  chk_cnt_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    (bank_select_n || (proc_addr_strobe_n && ctrl_addr_strobe_n)) && burst_advance_n
      |=> $stable(cnt_reg) && $stable(addr_reg))
    else $error("counter moved without advance");
  chk_cnt_step: assert property (@(posedge mclk) disable iff (!arst_n)
    (bank_select_n || (proc_addr_strobe_n && ctrl_addr_strobe_n)) && !burst_advance_n
      |=> cnt_reg != $past(cnt_reg))
    else $error("counter did not step");
  chk_deselect: assert property (@(posedge mclk) disable iff (!arst_n)
    bank_select_n && !ctrl_addr_strobe_n |=> &data_lines_oe_n)
    else $error("driving after deselect");

endmodule : bssp_port

// ---- tb/bssp_host.sv ----
/*
  Host model: processor and cache controller sharing the port pins.
  Assumes mclk from the bench; every pin changes just after a rising edge.
*/
`timescale 1ns/1ps
module bssp_host (
  // Clock
  input wire logic mclk,
  // Pins toward the port
  output logic bank_select_n,
  output logic proc_addr_strobe_n,
  output logic ctrl_addr_strobe_n,
  output logic burst_advance_n,
  output logic write_upper_n,
  output logic write_lower_n,
  output logic out_drive_en_n,
  output logic [15:0] addr_in,
  output logic [15:0] data_lines_in,
  output logic [1:0] parity_lines_in
);
  initial begin
    {bank_select_n, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = 4'hF;
    {write_upper_n, write_lower_n, out_drive_en_n} = 3'h7;
    addr_in = 16'h0000;
    {parity_lines_in, data_lines_in} = 18'h2A5A5;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One cycle; wr is active high per lane, returns at the following falling edge
  task automatic step(input logic [3:0] ctl, input logic [1:0] wr, input logic oe,
                      input logic [15:0] a, input logic [17:0] w);
    @(posedge mclk);
    {bank_select_n, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} <= ctl;
    {write_upper_n, write_lower_n} <= ~wr;
    out_drive_en_n <= oe | (|wr);
    addr_in <= a;
    // A released bus shows no stale word, so it flips every idle cycle
    {parity_lines_in, data_lines_in} <= (|wr) ? w : ~{parity_lines_in, data_lines_in};
    @(negedge mclk);
  endtask : step
  // Early drives lanes low in the strobe cycle, where they must be ignored
  task automatic proc_write(input logic [15:0] a, input logic [17:0] w,
                            input logic [1:0] ln, input logic early);
    step(4'h3, early ? ln : 2'h0, 1'b1, a, ~w);
    step(4'h7, ln, 1'b1, a, w);
  endtask : proc_write
endmodule : bssp_host

// ---- tb/tb_top.sv ----
/*
  Self-checking bench of the burst port, both burst orders side by side.
  Assumes the host model drives the pins; a reference array predicts reads.
*/
`timescale 1ns/1ps
module tb_top;
  logic mclk, arst_n, bank_select_n, proc_addr_strobe_n, ctrl_addr_strobe_n;
  logic burst_advance_n, write_upper_n, write_lower_n, out_drive_en_n;
  logic [15:0] addr_in, data_lines_in, data_lines_out, data_lines_oe_n;
  logic [1:0] parity_lines_in, parity_lines_out, parity_lines_oe_n, ln, s;
  logic [17:0] ref_mem [logic [15:0]];
  logic [17:0] w, e;
  logic [15:0] lin_data_out, lin_data_oe_n;
  logic [1:0] lin_par_out, lin_par_oe_n;
  logic [15:0] a, base;
  int mismatches = 0, n_compared = 0, cycles = 0;
  bssp_port dut (.mclk, .arst_n, .bank_select_n, .proc_addr_strobe_n,
    .ctrl_addr_strobe_n, .burst_advance_n, .write_upper_n, .write_lower_n,
    .out_drive_en_n, .addr_in, .data_lines_in, .data_lines_out, .data_lines_oe_n,
    .parity_lines_in, .parity_lines_out, .parity_lines_oe_n);
  // Same pins and array contents; only the burst order differs
  bssp_port #(.ORDER(bssp_pkg::BSSP_ORDER_LINEAR)) dut_lin (.mclk, .arst_n,
    .bank_select_n, .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_advance_n,
    .write_upper_n, .write_lower_n, .out_drive_en_n, .addr_in, .data_lines_in,
    .data_lines_out(lin_data_out), .data_lines_oe_n(lin_data_oe_n), .parity_lines_in,
    .parity_lines_out(lin_par_out), .parity_lines_oe_n(lin_par_oe_n));
  bssp_host host (.mclk, .bank_select_n, .proc_addr_strobe_n, .ctrl_addr_strobe_n,
    .burst_advance_n, .write_upper_n, .write_lower_n, .out_drive_en_n, .addr_in,
    .data_lines_in, .parity_lines_in);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [17:0] merge(logic [17:0] old, logic [17:0] nw, logic [1:0] l);
    logic [17:0] m;
    m = {l[1], l[0], {8{l[1]}}, {8{l[0]}}};
    return (nw & m) | (old & ~m);
  endfunction : merge
  // Low address bits of the k-th word of a burst: interleaved XORs, linear adds
  function automatic logic [1:0] burst_low(logic [1:0] st, int k, bit lin);
    return lin ? 2'(st + 2'(k)) : 2'(st ^ 2'(k));
  endfunction : burst_low
  task automatic chk(input string name, input logic [17:0] seen, input logic [17:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      mismatches++;
    end
  endtask : chk
  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Run is about 700 cycles; the ceiling leaves wide margin
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    arst_n = 1'b0;
    void'($urandom(82));
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      base = 16'($urandom) & 16'hFFFC;
      for (int j = 0; j < 4; j++) begin
        w = 18'($urandom);
        host.step(4'h5, 2'h3, 1'b0, base | 16'(j), w);
        ref_mem[base | 16'(j)] = w;
      end
      a = base | 16'($urandom % 4);
      w = 18'($urandom);
      ln = 2'($urandom % 3 + 1);
      host.proc_write(a, w, ln, i[0]);
      ref_mem[a] = merge(ref_mem[a], w, ln);
      a = base | 16'($urandom % 4);
      w = 18'($urandom);
      ln = 2'($urandom % 3 + 1);
      host.step(4'h5, ln, 1'b0, a, w);
      ref_mem[a] = merge(ref_mem[a], w, ln);
      s = 2'($urandom);
      // Advance, low with the strobe when i[1] is clear, must not step the counter
      host.step({1'b0, i[2], ~i[2], i[1]}, 2'h0, 1'b0, base | 16'(s), 18'h0);
      for (int k = 0; k < 5; k++) begin
        // Last two steps: idle, then processor strobe while unselected
        host.step(k < 3 ? 4'h6 : (k == 3 ? 4'h7 : 4'hB), 2'h0, 1'b0, ~base, 18'h0);
        e = ref_mem[base | 16'(burst_low(s, k > 3 ? 3 : k, 1'b0))];
        chk("read", {parity_lines_out, data_lines_out}, e);
        e = ref_mem[base | 16'(burst_low(s, k > 3 ? 3 : k, 1'b1))];
        chk("lin read", {lin_par_out, lin_data_out}, e);
        chk("drive", {parity_lines_oe_n, data_lines_oe_n}, 18'h00000);
      end
      host.step(4'h7, 2'h0, 1'b0, base, 18'h0);
      chk("held", {parity_lines_out, data_lines_out}, ref_mem[base | 16'(s ^ 2'h3)]);
      e = ref_mem[base | 16'(burst_low(s, 3, 1'b1))];
      chk("lin held", {lin_par_out, lin_data_out}, e);
      host.step(4'h7, 2'h0, 1'b1, base, 18'h0);
      chk("drive off", {parity_lines_oe_n, data_lines_oe_n}, 18'h3FFFF);
      host.step(4'hD, 2'h0, 1'b0, base, 18'h0);
      host.step(4'h7, 2'h0, 1'b0, base, 18'h0);
      chk("deselect", {parity_lines_oe_n, data_lines_oe_n}, 18'h3FFFF);
      chk("lin deselect", {lin_par_oe_n, lin_data_oe_n}, 18'h3FFFF);
    end
    stop_test();
  end
endmodule : tb_top
